/* File: rtl/engine_state_reporter.sv */
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
// Summary of operation
// - Task state in substate bits 1:0
// - Report on query, change request, spontaneously
// - Only defined machine states are reported
// - Done after all banks, cycle down finished
// - Done after reset, abort all, last-job abort
// - Running while processing banks normally
// - End-of-job bank: restartable when spin-down begins
// - Down request keeps running, then incomplete
// - Restartable on end-of-job bank while printing
// - Restartable becomes done after spin-down completes with no banks pending
// - Early spin-down end makes task incomplete
// - Fault bit clear when no blocking fault
// - Fault bit set on blocking fault
// - Volunteer report at power-up, change, fault
module engine_state_reporter #(
  parameter int BANK_W = 4
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Host commands, one-cycle pulses
  input wire logic next_batch_cmd_i,
  input wire logic state_change_cmd_i,
  input wire logic change_to_up_i,
  input wire logic state_query_cmd_i,
  input wire logic host_global_reset_cmd_i,
  input wire logic batch_abort_cmd_i,
  input wire logic abort_all_i,
  // Engine events
  input wire logic spin_up_done_i,
  input wire logic spin_down_done_i,
  input wire logic bank_done_i,
  input wire logic job_last_flag_i,
  input wire logic fault_present_i,
  // Report byte stream
  output logic msg_valid_o,
  output logic [7:0] msg_byte_o,
  output logic msg_last_o,
  input wire logic msg_ready_i,
  // Register port
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o
);

  reporter_pkg::machine_t ms_q;
  reporter_pkg::tx_t tx_q;
  logic [1:0] task_q;
  logic [BANK_W-1:0] pending_q;
  logic fault_q;
  logic [7:0] ctrl_q;
  logic rep_pend_q;
  logic [7:0] prev_mach_q;
  logic [7:0] prev_sub_q;
  logic [1:0] idx_q;
  logic [7:0] sh_mach_q;
  logic [7:0] sh_sub_q;

  logic nonprod;
  logic ok;
  logic stopped;
  logic cycled_up;
  logic up_req;
  logic down_req;
  logic fault_rise;
  logic start_up;
  logic eoj_down;
  logic go_down;
  logic down_done;
  logic kill;
  logic [7:0] cur_mach;
  logic [7:0] cur_sub;
  logic changed;
  logic tx_start;
  logic tx_step;

  function automatic logic [7:0] mach_code(input reporter_pkg::machine_t m);
    logic [7:0] c;
    c = reporter_pkg::CODE_STOP_READY;
    case (m)
      reporter_pkg::ST_STOP_READY: c = reporter_pkg::CODE_STOP_READY;
      reporter_pkg::ST_STOP_UNREADY: c = reporter_pkg::CODE_STOP_UNREADY;
      reporter_pkg::ST_SPIN_DOWN: c = reporter_pkg::CODE_SPIN_DOWN;
      reporter_pkg::ST_SPIN_UP: c = reporter_pkg::CODE_SPIN_UP;
      reporter_pkg::ST_RUN_OUTPUT: c = reporter_pkg::CODE_RUN_OUTPUT;
      reporter_pkg::ST_RUN_IDLE: c = reporter_pkg::CODE_RUN_IDLE;
      default: c = reporter_pkg::CODE_STOP_UNREADY;
    endcase
    return c;
  endfunction

  // A blocking fault always implies non-productive
  assign nonprod = ctrl_q[reporter_pkg::CTRL_NONPROD_BIT] | fault_q;
  assign ok = !nonprod && !fault_present_i;
  assign stopped = (ms_q == reporter_pkg::ST_STOP_READY) || (ms_q == reporter_pkg::ST_STOP_UNREADY);
  assign cycled_up = (ms_q == reporter_pkg::ST_RUN_OUTPUT) || (ms_q == reporter_pkg::ST_RUN_IDLE)
    || (ms_q == reporter_pkg::ST_SPIN_UP);
  assign up_req = state_change_cmd_i && change_to_up_i;
  assign down_req = state_change_cmd_i && !change_to_up_i;
  assign fault_rise = fault_present_i && !fault_q;
  assign kill = host_global_reset_cmd_i
    || (batch_abort_cmd_i && (abort_all_i || pending_q == BANK_W'(1)));
  assign start_up = ok && (up_req || next_batch_cmd_i) && (stopped
    || (ms_q == reporter_pkg::ST_SPIN_DOWN && task_q == reporter_pkg::TASK_RESTARTABLE));
  assign eoj_down = bank_done_i && job_last_flag_i && ms_q == reporter_pkg::ST_RUN_OUTPUT;
  assign go_down = eoj_down || (cycled_up && (down_req || fault_rise || host_global_reset_cmd_i));
  assign down_done = spin_down_done_i && ms_q == reporter_pkg::ST_SPIN_DOWN;

  // Reported machine state: one of the six defined codes
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ms_q <= reporter_pkg::ST_STOP_READY;
    else if (start_up)
      ms_q <= reporter_pkg::ST_SPIN_UP;
    else if (go_down)
      ms_q <= reporter_pkg::ST_SPIN_DOWN;
    else if (spin_up_done_i && ms_q == reporter_pkg::ST_SPIN_UP)
      ms_q <= (pending_q != '0 && ok) ? reporter_pkg::ST_RUN_OUTPUT : reporter_pkg::ST_RUN_IDLE;
    else if (ms_q == reporter_pkg::ST_RUN_OUTPUT && !ok)
      ms_q <= reporter_pkg::ST_RUN_IDLE;
    else if (ms_q == reporter_pkg::ST_RUN_IDLE && ok && pending_q != '0)
      ms_q <= reporter_pkg::ST_RUN_OUTPUT;
    else if (down_done || stopped)
      ms_q <= (nonprod || fault_present_i) ? reporter_pkg::ST_STOP_UNREADY : reporter_pkg::ST_STOP_READY;
  end

  // Task substate transitions
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      task_q <= reporter_pkg::TASK_DONE;
    else if (kill)
      task_q <= reporter_pkg::TASK_DONE;
    else if (start_up)
      task_q <= reporter_pkg::TASK_RUNNING;
    else if (eoj_down)
      task_q <= reporter_pkg::TASK_RESTARTABLE;
    else if (down_done)
    begin
      if (task_q == reporter_pkg::TASK_RESTARTABLE && pending_q == '0)
        task_q <= reporter_pkg::TASK_DONE;
      else if (task_q != reporter_pkg::TASK_DONE)
        task_q <= reporter_pkg::TASK_INCOMPLETE;
    end
  end

  // Banks received but not yet processed
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pending_q <= '0;
    else if (host_global_reset_cmd_i || (batch_abort_cmd_i && abort_all_i))
      pending_q <= '0;
    else if ((next_batch_cmd_i && !(&pending_q))
        && !((bank_done_i || batch_abort_cmd_i) && pending_q != '0))
      pending_q <= pending_q + BANK_W'(1);
    else if (!next_batch_cmd_i && (bank_done_i || batch_abort_cmd_i) && pending_q != '0)
      pending_q <= pending_q - BANK_W'(1);
  end

  // Fault level and control register
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      fault_q <= 1'b0;
    else
      fault_q <= fault_present_i;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ctrl_q <= reporter_pkg::CTRL_RESET;
    else if (reg_wr_i && reg_addr_i == reporter_pkg::ADDR_CTRL)
      ctrl_q <= reg_wdata_i;
  end

  assign cur_mach = mach_code(ms_q);
  assign cur_sub = {reporter_pkg::SPARE_BITS, nonprod, fault_q, task_q};
  assign changed = (cur_mach != prev_mach_q) || (cur_sub != prev_sub_q);

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      prev_mach_q <= reporter_pkg::CODE_STOP_READY;
      prev_sub_q <= 8'h00;
    end
    else
    begin
      prev_mach_q <= cur_mach;
      prev_sub_q <= cur_sub;
    end
  end

  // Pending report; set wins over the clear at send start
  assign tx_start = (tx_q == reporter_pkg::TX_IDLE) && rep_pend_q;
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rep_pend_q <= 1'b1;
    else if (state_query_cmd_i || state_change_cmd_i || changed)
      rep_pend_q <= 1'b1;
    else if (tx_start)
      rep_pend_q <= 1'b0;
  end

  // Three-byte report sender
  assign tx_step = msg_valid_o && msg_ready_i;
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tx_q <= reporter_pkg::TX_IDLE;
      idx_q <= reporter_pkg::IDX_ID;
      sh_mach_q <= reporter_pkg::CODE_STOP_READY;
      sh_sub_q <= 8'h00;
      msg_valid_o <= 1'b0;
      msg_byte_o <= 8'h00;
      msg_last_o <= 1'b0;
    end
    else
    begin
      case (tx_q)
        reporter_pkg::TX_IDLE:
          if (rep_pend_q)
          begin
            tx_q <= reporter_pkg::TX_BYTE;
            idx_q <= reporter_pkg::IDX_ID;
            sh_mach_q <= cur_mach;
            sh_sub_q <= cur_sub;
            msg_valid_o <= 1'b1;
            msg_byte_o <= reporter_pkg::REPORT_ID;
            msg_last_o <= 1'b0;
          end
        reporter_pkg::TX_BYTE:
          if (tx_step)
          begin
            case (idx_q)
              reporter_pkg::IDX_ID:
              begin
                idx_q <= reporter_pkg::IDX_MACHINE;
                msg_byte_o <= sh_mach_q;
              end
              reporter_pkg::IDX_MACHINE:
              begin
                idx_q <= reporter_pkg::IDX_SUBSTATE;
                msg_byte_o <= sh_sub_q;
                msg_last_o <= 1'b1;
              end
              default:
              begin
                tx_q <= reporter_pkg::TX_IDLE;
                idx_q <= reporter_pkg::IDX_ID;
                msg_valid_o <= 1'b0;
                msg_byte_o <= 8'h00;
                msg_last_o <= 1'b0;
              end
            endcase
          end
        default:
          tx_q <= reporter_pkg::TX_IDLE;
      endcase
    end
  end

  // Register read, data valid the cycle after the strobe
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        reporter_pkg::ADDR_CTRL: reg_rdata_o <= ctrl_q;
        reporter_pkg::ADDR_MACHINE: reg_rdata_o <= cur_mach;
        reporter_pkg::ADDR_SUBSTATE: reg_rdata_o <= cur_sub;
        default: reg_rdata_o <= 8'(pending_q);
      endcase
    end
    else
      reg_rdata_o <= 8'h00;
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);

  run_on_start_a: assert property (
    start_up && !kill |=> task_q == reporter_pkg::TASK_RUNNING && ms_q == reporter_pkg::ST_SPIN_UP)
    else $error("start did not give running task");

  query_report_a: assert property (
    state_query_cmd_i |=> rep_pend_q)
    else $error("query did not schedule a report");

  machine_code_a: assert property (
    msg_valid_o && idx_q == reporter_pkg::IDX_MACHINE |-> msg_byte_o <= reporter_pkg::CODE_RUN_IDLE)
    else $error("spare machine code sent");

  done_cause_a: assert property (
    task_q == reporter_pkg::TASK_DONE && $past(task_q) != reporter_pkg::TASK_DONE
    |-> $past(kill) || ($past(down_done) && $past(task_q) == reporter_pkg::TASK_RESTARTABLE))
    else $error("task done without cause");

  eoj_restart_a: assert property (
    eoj_down && !kill && !start_up
    |=> task_q == reporter_pkg::TASK_RESTARTABLE && ms_q == reporter_pkg::ST_SPIN_DOWN)
    else $error("end of job did not give restartable");

  early_end_a: assert property (
    down_done && task_q == reporter_pkg::TASK_RUNNING && !kill && !start_up
    |=> task_q == reporter_pkg::TASK_INCOMPLETE)
    else $error("early spin-down not incomplete");

  hold_running_a: assert property (
    ms_q == reporter_pkg::ST_SPIN_DOWN && task_q == reporter_pkg::TASK_RUNNING
    && !spin_down_done_i && !kill |=> task_q == reporter_pkg::TASK_RUNNING)
    else $error("running lost during spin-down");

  reset_done_a: assert property (
    host_global_reset_cmd_i |=> task_q == reporter_pkg::TASK_DONE && pending_q == '0)
    else $error("reset did not complete task");

  substate_bits_a: assert property (
    msg_valid_o && msg_last_o |-> msg_byte_o[7:4] == reporter_pkg::SPARE_BITS
    && (!msg_byte_o[reporter_pkg::FAULT_BIT] || msg_byte_o[reporter_pkg::PROD_BIT]))
    else $error("bad substate byte");

  volunteer_a: assert property (
    $changed(ms_q) || $rose(fault_q) |=> rep_pend_q)
    else $error("state change not volunteered");

endmodule

/* File: rtl/reporter_pkg.sv */
package reporter_pkg;
  // Report message layout
  localparam logic [7:0] REPORT_ID = 8'h87;
  localparam logic [1:0] IDX_ID = 2'h0;
  localparam logic [1:0] IDX_MACHINE = 2'h1;
  localparam logic [1:0] IDX_SUBSTATE = 2'h2;
  // Machine-state byte codes
  localparam logic [7:0] CODE_STOP_READY = 8'h00;
  localparam logic [7:0] CODE_STOP_UNREADY = 8'h01;
  localparam logic [7:0] CODE_SPIN_DOWN = 8'h02;
  localparam logic [7:0] CODE_SPIN_UP = 8'h03;
  localparam logic [7:0] CODE_RUN_OUTPUT = 8'h04;
  localparam logic [7:0] CODE_RUN_IDLE = 8'h05;
  // Task substate codes
  localparam logic [1:0] TASK_DONE = 2'h0;
  localparam logic [1:0] TASK_RUNNING = 2'h1;
  localparam logic [1:0] TASK_RESTARTABLE = 2'h2;
  localparam logic [1:0] TASK_INCOMPLETE = 2'h3;
  // Substate byte fields
  localparam int FAULT_BIT = 2;
  localparam int PROD_BIT = 3;
  localparam logic [3:0] SPARE_BITS = 4'h0;
  // Register port map
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_MACHINE = 2'h1;
  localparam logic [1:0] ADDR_SUBSTATE = 2'h2;
  localparam logic [1:0] ADDR_BANKS = 2'h3;
  localparam int CTRL_NONPROD_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  typedef enum logic [5:0] {
    ST_STOP_READY = 6'b000001,
    ST_STOP_UNREADY = 6'b000010,
    ST_SPIN_DOWN = 6'b000100,
    ST_SPIN_UP = 6'b001000,
    ST_RUN_OUTPUT = 6'b010000,
    ST_RUN_IDLE = 6'b100000
  } machine_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_BYTE = 2'b10
  } tx_t;
endpackage

/* File: dv/psp_model.sv */
`timescale 1ns/1ps
module psp_model (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Pacing, 1 = accept every other cycle
  input wire logic slow_i,
  // Report stream
  input wire logic msg_valid_i,
  input wire logic [7:0] msg_byte_i,
  input wire logic msg_last_i,
  output logic msg_ready_o,
  // Collected messages
  output logic [23:0] msg_o,
  output int count_o,
  output logic frame_err_o
);
  logic [15:0] head_q;
  logic [1:0] idx_q;

  always_ff @(posedge ref_clk_i or negedge rstn_i)
    if (!rstn_i)
      msg_ready_o <= 1'b0;
    else
      msg_ready_o <= slow_i ? ~msg_ready_o : 1'b1;

  // Assemble three-byte messages, flag bad framing
  always_ff @(posedge ref_clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      head_q <= 16'h0000;
      idx_q <= 2'h0;
      msg_o <= 24'h000000;
      count_o <= 0;
      frame_err_o <= 1'b0;
    end
    else if (msg_valid_i && msg_ready_o)
    begin
      head_q <= {head_q[7:0], msg_byte_i};
      idx_q <= msg_last_i ? 2'h0 : idx_q + 2'h1;
      if (msg_last_i != (idx_q == 2'h2))
        frame_err_o <= 1'b1;
      if (idx_q == 2'h0 && msg_byte_i !== reporter_pkg::REPORT_ID)
        frame_err_o <= 1'b1;
      if (msg_last_i)
      begin
        msg_o <= {head_q, msg_byte_i};
        count_o <= count_o + 1;
      end
    end
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  // Pulses: 0 bank,1 change,2 query,3 reset,4 abort,5 up done,6 down done,7 bank done
  logic [7:0] cmd = 8'h00;
  logic up = 1'b0;
  logic all = 1'b0;
  logic last = 1'b0;
  logic flt = 1'b0;
  logic slow = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [7:0] mbyte;
  logic vld;
  logic lst;
  logic rdy;
  logic ferr;
  logic [23:0] msg;
  int n;
  int err_count = 0;
  int comparisons = 0;

  always #25 ref_clk_i = ~ref_clk_i;

  engine_state_reporter dut_u (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .next_batch_cmd_i(cmd[0]),
    .state_change_cmd_i(cmd[1]), .change_to_up_i(up), .state_query_cmd_i(cmd[2]),
    .host_global_reset_cmd_i(cmd[3]), .batch_abort_cmd_i(cmd[4]), .abort_all_i(all),
    .spin_up_done_i(cmd[5]), .spin_down_done_i(cmd[6]), .bank_done_i(cmd[7]),
    .job_last_flag_i(last), .fault_present_i(flt), .msg_valid_o(vld),
    .msg_byte_o(mbyte), .msg_last_o(lst), .msg_ready_i(rdy), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata)
  );

  psp_model psp_u (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .slow_i(slow), .msg_valid_i(vld),
    .msg_byte_i(mbyte), .msg_last_i(lst), .msg_ready_o(rdy), .msg_o(msg),
    .count_o(n), .frame_err_o(ferr)
  );

  task automatic final_report();
    if (err_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: byte %h, want %h", $time, got, exp);
    end
  endtask

  task automatic cmp_m(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: message %h, want %h", $time, got, exp);
    end
  endtask

  task automatic pulse(input int i);
    @(posedge ref_clk_i);
    cmd <= 8'(1 << i);
    @(posedge ref_clk_i);
    cmd <= 8'h00;
    repeat (3) @(posedge ref_clk_i);
  endtask

  task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1;
    cmp(rdata, exp);
  endtask

  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask

  // Waits for a new message, then lets merged follow-ups settle
  task automatic wait_msg(input int n0, input logic [23:0] exp);
    repeat (60) if (n == n0) @(posedge ref_clk_i);
    repeat (30) @(posedge ref_clk_i);
    cmp({7'h00, n > n0}, 8'h01);
    cmp_m(msg, exp);
  endtask

  task automatic t_power();
    wait_msg(0, 24'h870000);
    rd_chk(2'h0, reporter_pkg::CTRL_RESET);
  endtask

  task automatic t_query();
    int n0;
    n0 = n;
    slow <= 1'b1;
    pulse(2);
    wait_msg(n0, 24'h870000);
    slow <= 1'b0;
  endtask

  task automatic t_job();
    pulse(0);
    up <= 1'b1;
    pulse(1);
    rd_chk(2'h1, reporter_pkg::CODE_SPIN_UP);
    pulse(5);
    rd_chk(2'h1, reporter_pkg::CODE_RUN_OUTPUT);
    rd_chk(2'h2, 8'h01);
    last <= 1'b1;
    pulse(7);
    last <= 1'b0;
    rd_chk(2'h2, 8'h02);
    rd_chk(2'h1, reporter_pkg::CODE_SPIN_DOWN);
    pulse(6);
    rd_chk(2'h2, 8'h00);
    rd_chk(2'h1, reporter_pkg::CODE_STOP_READY);
  endtask

  task automatic t_down();
    pulse(0);
    pulse(0);
    up <= 1'b1;
    pulse(1);
    pulse(5);
    up <= 1'b0;
    pulse(1);
    rd_chk(2'h2, 8'h01);
    pulse(6);
    rd_chk(2'h2, 8'h03);
    pulse(3);
    rd_chk(2'h2, 8'h00);
    pulse(0);
    all <= 1'b1;
    pulse(4);
    rd_chk(2'h3, 8'h00);
  endtask

  task automatic t_fault();
    int n0;
    n0 = n;
    flt <= 1'b1;
    // Engine is still spinning up after the abort, so the fault forces spin-down
    wait_msg(n0, 24'h87020C);
    pulse(6);
    rd_chk(2'h1, reporter_pkg::CODE_STOP_UNREADY);
    rd_chk(2'h2, 8'h0C);
    flt <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rd_chk(2'h2, 8'h00);
  endtask

  task automatic t_ctrl();
    wr_reg(2'h0, 8'h01);
    rd_chk(2'h0, 8'h01);
    rd_chk(2'h2, 8'h08);
    wr_reg(2'h1, 8'hFF);
    rd_chk(2'h1, reporter_pkg::CODE_STOP_UNREADY);
    wr_reg(2'h0, 8'h00);
    rd_chk(2'h1, reporter_pkg::CODE_STOP_READY);
  endtask

  initial
  begin
    repeat (2) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    t_power();
    t_query();
    t_job();
    t_down();
    t_fault();
    t_ctrl();
    cmp({7'h00, ferr}, 8'h00);
    final_report();
  end

  initial
  begin
    #1000000;
    err_count++;
    final_report();
  end
endmodule
